// ---- rtl/ueb_defines.vh ----
// Constants for the OTG event and accessory UART register bank
`ifndef UEB_DEFINES_VH
`define UEB_DEFINES_VH

// Register indices; byte address is index times four
`define UEB_IDX_IFC_WR      6'h07
`define UEB_IDX_IFC_SET     6'h08
`define UEB_IDX_IFC_CLR     6'h09
`define UEB_IDX_RISE_WR     6'h0d
`define UEB_IDX_RISE_SET    6'h0e
`define UEB_IDX_RISE_CLR    6'h0f
`define UEB_IDX_FALL_WR     6'h10
`define UEB_IDX_FALL_SET    6'h11
`define UEB_IDX_FALL_CLR    6'h12
`define UEB_IDX_STATUS      6'h13
`define UEB_IDX_LATCH       6'h14
`define UEB_IDX_DEBUG       6'h15
`define UEB_IDX_SCR_WR      6'h16
`define UEB_IDX_SCR_SET     6'h17
`define UEB_IDX_SCR_CLR     6'h18
`define UEB_IDX_ACC_WR      6'h19
`define UEB_IDX_ACC_SET     6'h1a
`define UEB_IDX_ACC_CLR     6'h1b
`define UEB_IDX_IRQ_MASK    6'h30

// Address slice holding the index
`define UEB_IDX_HI          7
`define UEB_IDX_LO          2

// Write operations of a three-address group
`define UEB_OP_WRITE        2'h0
`define UEB_OP_SET          2'h1
`define UEB_OP_CLEAR        2'h2

// Field layouts and reset values
`define UEB_NUM_EVT         5
`define UEB_EVT_MASK        8'h1f
`define UEB_DBG_MASK        8'h03
`define UEB_ACC_MASK        8'h0e
`define UEB_SCR_MASK        8'hff
`define UEB_IFC_MASK        8'h04
`define UEB_EDGE_RST        8'h1f
`define UEB_ZERO_RST        8'h00
`define UEB_EVT_HOST_DISC   0
`define UEB_ACC_ID_LOW      1
`define UEB_ACC_TX_EN       2
`define UEB_ACC_RX_EN       3
`define UEB_IFC_ACC_MODE    2

// Bus encodings
`define UEB_HTRANS_NONSEQ_B 1
`define UEB_HRESP_OKAY      1'h0

`endif

// ---- rtl/ueb_regs.v ----
// OTG event and accessory UART register bank with an AHB-Lite slave port
//
// Function
// - Rise enables: write, set, clear at three addresses
// - Fall enables: same three-address scheme
// - Rise enable bits 0-4 reset to one
// - Fall enable bits 0-4 reset to one
// - Detach events count only in host mode
// - Status returns live comparator levels
// - Status follows comparators, no fixed reset
// - Enabled edge sets its latch bit
// - Latch read returns then clears all bits without a new event that cycle
// - Debug returns line state in bits 1-0
// - Scratch byte read/write/set/clear, resets zero
// - Accessory control uses three-address scheme
// - Transmit enable drives data0 onto DM
// - Receive enable routes DP onto data1
// - Receive disabled holds data1 high
// - Accessory mode bit, cleared on mode exit
//
// Local design decision: the AHB-Lite interface to the registers.
`include "ueb_defines.vh"
`default_nettype none

module ueb_regs
(
  input  wire        i_ref_clk,
  input  wire        i_reset,
  input  wire        i_hsel,
  input  wire [31:0] i_haddr,
  input  wire [1:0]  i_htrans,
  input  wire        i_hwrite,
  input  wire [2:0]  i_hsize,
  input  wire [31:0] i_hwdata,
  input  wire        i_hready,
  output reg         o_hreadyout,
  output reg         o_hresp,
  output reg  [31:0] o_hrdata,
  input  wire        i_host_mode,
  input  wire        i_host_disconnect,
  input  wire        i_vbus_valid,
  input  wire        i_session_present,
  input  wire        i_below_session_threshold,
  input  wire        i_id_pin_grounded,
  input  wire [1:0]  i_line_state,
  input  wire        i_accessory_mode_exit,
  input  wire        i_uart_tx_data,
  input  wire        i_dp_level,
  output reg         o_dm_uart_data,
  output reg         o_dm_uart_oe_n,
  output reg         o_uart_rx_data,
  output reg         o_id_pull_low_drive,
  output reg         o_accessory_uart_mode,
  output reg         o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  reg  [7:0] rise_en_reg;
  reg  [7:0] fall_en_reg;
  reg  [7:0] latch_reg;
  reg  [7:0] scratch_reg;
  reg  [7:0] acc_ctrl_reg;
  reg  [7:0] ifc_ctrl_reg;
  reg  [7:0] irq_mask_reg;
  reg  [4:0] cmp_prev_reg;
  reg        wr_pend_reg;
  reg        rd_pend_reg;
  reg  [5:0] idx_reg;

  wire [4:0] cmp_now;
  wire [4:0] evt;
  wire [5:0] idx_addr;
  wire       accept;
  wire [7:0] wdat;

  // Comparator levels arrive already synchronous to this clock
  assign cmp_now  = {i_id_pin_grounded, i_below_session_threshold,
                     i_session_present, i_vbus_valid, i_host_disconnect};
  // Upper address bits are ignored, so the bank aliases every 256 bytes
  assign idx_addr = i_haddr[`UEB_IDX_HI:`UEB_IDX_LO];
  assign accept   = i_hsel & i_htrans[`UEB_HTRANS_NONSEQ_B] & i_hready;
  assign wdat     = i_hwdata[7:0];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection per comparator

  genvar g;
  generate
    for (g = 0; g < `UEB_NUM_EVT; g = g + 1)
    begin : g_evt
      wire rise;
      wire fall;
      wire allowed;
      assign rise    = cmp_now[g] & ~cmp_prev_reg[g];
      assign fall    = ~cmp_now[g] & cmp_prev_reg[g];
      // Detach edges are meaningless outside host mode
      assign allowed = (g != `UEB_EVT_HOST_DISC) | i_host_mode;
      assign evt[g]  = allowed & ((rise & rise_en_reg[g]) | (fall & fall_en_reg[g]));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Three-address write helper

  function [7:0] apply_op;
    input [7:0] old;
    input [7:0] data;
    input [1:0] op;
    input [7:0] mask;
    begin
      case (op)
        `UEB_OP_WRITE: apply_op = data & mask;
        `UEB_OP_SET:   apply_op = (old | data) & mask;
        `UEB_OP_CLEAR: apply_op = old & ~data & mask;
        default:       apply_op = old;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; reserved bits and unmapped addresses read zero

  reg [7:0] rd_val;
  always @*
  begin
    case (idx_reg)
      `UEB_IDX_IFC_WR, `UEB_IDX_IFC_SET, `UEB_IDX_IFC_CLR:
        rd_val = ifc_ctrl_reg;
      `UEB_IDX_RISE_WR, `UEB_IDX_RISE_SET, `UEB_IDX_RISE_CLR:
        rd_val = rise_en_reg;
      `UEB_IDX_FALL_WR, `UEB_IDX_FALL_SET, `UEB_IDX_FALL_CLR:
        rd_val = fall_en_reg;
      `UEB_IDX_STATUS:
        rd_val = {3'h0, cmp_now};
      `UEB_IDX_LATCH:
        rd_val = latch_reg;
      `UEB_IDX_DEBUG:
        rd_val = {6'h00, i_line_state};
      `UEB_IDX_SCR_WR, `UEB_IDX_SCR_SET, `UEB_IDX_SCR_CLR:
        rd_val = scratch_reg;
      `UEB_IDX_ACC_WR, `UEB_IDX_ACC_SET, `UEB_IDX_ACC_CLR:
        rd_val = acc_ctrl_reg;
      `UEB_IDX_IRQ_MASK:
        rd_val = irq_mask_reg;
      default:
        rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes complete with no wait, reads take one wait state
  // so that a read right behind a write sees the written value.

  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_hreadyout <= 1'h1;
      o_hresp     <= `UEB_HRESP_OKAY;
      o_hrdata    <= 32'h00000000;
      wr_pend_reg <= 1'h0;
      rd_pend_reg <= 1'h0;
      idx_reg     <= 6'h00;
    end
    else
    begin
      o_hresp     <= `UEB_HRESP_OKAY;
      wr_pend_reg <= accept & i_hwrite;
      rd_pend_reg <= accept & ~i_hwrite;
      if (accept)
      begin
        idx_reg <= idx_addr;
      end
      if (accept & ~i_hwrite)
      begin
        o_hreadyout <= 1'h0;
      end
      else
      begin
        o_hreadyout <= 1'h1;
      end
      // Registered read data costs a wait state but keeps the bus path short
      if (rd_pend_reg)
      begin
        o_hrdata <= {24'h000000, rd_val};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register updates

  wire       wr_now;
  wire       latch_rd;
  wire       in_mask;
  wire [5:0] off_ifc;
  wire [5:0] off_rise;
  wire [5:0] off_fall;
  wire [5:0] off_scr;
  wire [5:0] off_acc;
  wire [1:0] op_ifc;
  wire [1:0] op_rise;
  wire [1:0] op_fall;
  wire [1:0] op_scr;
  wire [1:0] op_acc;

  assign wr_now   = wr_pend_reg;
  assign latch_rd = rd_pend_reg & (idx_reg == `UEB_IDX_LATCH);
  assign in_mask  = (idx_reg == `UEB_IDX_IRQ_MASK);

  // Distance from the group base selects write, set or clear
  assign off_ifc  = idx_reg - `UEB_IDX_IFC_WR;
  assign off_rise = idx_reg - `UEB_IDX_RISE_WR;
  assign off_fall = idx_reg - `UEB_IDX_FALL_WR;
  assign off_scr  = idx_reg - `UEB_IDX_SCR_WR;
  assign off_acc  = idx_reg - `UEB_IDX_ACC_WR;
  assign op_ifc   = off_ifc[1:0];
  assign op_rise  = off_rise[1:0];
  assign op_fall  = off_fall[1:0];
  assign op_scr   = off_scr[1:0];
  assign op_acc   = off_acc[1:0];

  wire in_ifc;
  wire in_rise;
  wire in_fall;
  wire in_scr;
  wire in_acc;

  assign in_ifc  = (idx_reg >= `UEB_IDX_IFC_WR)  & (idx_reg <= `UEB_IDX_IFC_CLR);
  assign in_rise = (idx_reg >= `UEB_IDX_RISE_WR) & (idx_reg <= `UEB_IDX_RISE_CLR);
  assign in_fall = (idx_reg >= `UEB_IDX_FALL_WR) & (idx_reg <= `UEB_IDX_FALL_CLR);
  assign in_scr  = (idx_reg >= `UEB_IDX_SCR_WR)  & (idx_reg <= `UEB_IDX_SCR_CLR);
  assign in_acc  = (idx_reg >= `UEB_IDX_ACC_WR)  & (idx_reg <= `UEB_IDX_ACC_CLR);

  reg [7:0] ifc_next;
  always @*
  begin
    ifc_next = ifc_ctrl_reg;
    if (wr_now & in_ifc)
    begin
      ifc_next = apply_op(ifc_ctrl_reg, wdat, op_ifc, `UEB_IFC_MASK);
    end
    // Leaving the mode wins over a write in the same cycle
    if (i_accessory_mode_exit)
    begin
      ifc_next[`UEB_IFC_ACC_MODE] = 1'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next values of the software registers

  reg [7:0] rise_next;
  reg [7:0] fall_next;
  reg [7:0] scratch_next;
  reg [7:0] acc_next;
  reg [7:0] mask_next;
  reg [7:0] latch_next;

  always @*
  begin
    rise_next    = rise_en_reg;
    fall_next    = fall_en_reg;
    scratch_next = scratch_reg;
    acc_next     = acc_ctrl_reg;
    mask_next    = irq_mask_reg;
    if (wr_now & in_rise)
    begin
      rise_next = apply_op(rise_en_reg, wdat, op_rise, `UEB_EVT_MASK);
    end
    if (wr_now & in_fall)
    begin
      fall_next = apply_op(fall_en_reg, wdat, op_fall, `UEB_EVT_MASK);
    end
    if (wr_now & in_scr)
    begin
      scratch_next = apply_op(scratch_reg, wdat, op_scr, `UEB_SCR_MASK);
    end
    if (wr_now & in_acc)
    begin
      acc_next = apply_op(acc_ctrl_reg, wdat, op_acc, `UEB_ACC_MASK);
    end
    if (wr_now & in_mask)
    begin
      mask_next = wdat & `UEB_EVT_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event latch

  // New event beats the read clear in the same cycle
  always @*
  begin
    if (latch_rd)
    begin
      latch_next = {3'h0, evt};
    end
    else
    begin
      latch_next = latch_reg | {3'h0, evt};
    end
  end

  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      rise_en_reg  <= `UEB_EDGE_RST;
      fall_en_reg  <= `UEB_EDGE_RST;
      latch_reg    <= `UEB_ZERO_RST;
      scratch_reg  <= `UEB_ZERO_RST;
      acc_ctrl_reg <= `UEB_ZERO_RST;
      ifc_ctrl_reg <= `UEB_ZERO_RST;
      irq_mask_reg <= `UEB_ZERO_RST;
      // Sample levels so release from reset raises no false edge
      cmp_prev_reg <= cmp_now;
    end
    else
    begin
      cmp_prev_reg <= cmp_now;
      rise_en_reg  <= rise_next;
      fall_en_reg  <= fall_next;
      scratch_reg  <= scratch_next;
      acc_ctrl_reg <= acc_next;
      irq_mask_reg <= mask_next;
      ifc_ctrl_reg <= ifc_next;
      latch_reg    <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accessory UART routing

  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_dm_uart_data        <= 1'h0;
      o_dm_uart_oe_n        <= 1'h1;
      o_uart_rx_data        <= 1'h1;
      o_id_pull_low_drive   <= 1'h0;
      o_accessory_uart_mode <= 1'h0;
    end
    else
    begin
      o_dm_uart_data        <= i_uart_tx_data;
      o_dm_uart_oe_n        <= ~acc_ctrl_reg[`UEB_ACC_TX_EN];
      // Idle UART line is high, so a disabled receive path looks idle
      o_uart_rx_data        <= acc_ctrl_reg[`UEB_ACC_RX_EN] ? i_dp_level : 1'h1;
      o_id_pull_low_drive   <= acc_ctrl_reg[`UEB_ACC_ID_LOW];
      o_accessory_uart_mode <= ifc_next[`UEB_IFC_ACC_MODE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output

  wire irq_any;

  // Level output stays high until a latch read clears the cause or a mask write disables it
  assign irq_any = |(latch_reg & irq_mask_reg);

  always @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_irq <= 1'h0;
    end
    else
    begin
      o_irq <= irq_any;
    end
  end

endmodule

`default_nettype wire

// ---- verif/test_otg_event_and_carkit_regs.sv ----
// Self-checking bench for the OTG event and accessory UART register bank
`include "ueb_defines.vh"
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module test_otg_event_and_carkit_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0;
  logic        rst = 1;
  logic        hsel = 0;
  logic [31:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic        hwrite = 0;
  logic [31:0] hwdata = 0;
  logic        host = 0;
  logic [4:0]  cmp = 0;
  logic [1:0]  ls = 0;
  logic        ext = 0;
  logic        run = 0;
  logic [31:0] hrdata;
  logic        hready, txd, dp, dm, oe_n, rxd, mode, irq, hresp, idd;
  logic [7:0]  v, d, e, m;
  logic [5:0]  b;
  int          error_cnt = 0;
  int          checks = 0;
  always #12.5 clk = ~clk;
  ueb_regs dut_u (.i_ref_clk(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .i_host_mode(host), .i_host_disconnect(cmp[0]), .i_vbus_valid(cmp[1]),
    .i_session_present(cmp[2]), .i_below_session_threshold(cmp[3]),
    .i_id_pin_grounded(cmp[4]), .i_line_state(ls), .i_accessory_mode_exit(ext),
    .i_uart_tx_data(txd), .i_dp_level(dp), .o_dm_uart_data(dm), .o_dm_uart_oe_n(oe_n),
    .o_uart_rx_data(rxd), .o_id_pull_low_drive(idd), .o_accessory_uart_mode(mode),
    .o_irq(irq));
  ueb_link_model lm_u (.i_ref_clk(clk), .i_run(run), .o_uart_tx_data(txd), .o_dp_level(dp));
  ////////////////////////////////////////
  task automatic results;
  begin
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task automatic wt;
    int n;
  begin
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 40)
      begin
        error_cnt++;
        results;
      end
      @(posedge clk);
    end
  end
  endtask
  // Expected register value after a write (0), set (1) or clear (2)
  function automatic logic [7:0] upd(input logic [7:0] o, input logic [7:0] x,
                                     input logic [7:0] m, input int k);
    case (k)
      0: return x & m;
      1: return (o | x) & m;
      default: return o & ~x & m;
    endcase
  endfunction
  // One single transfer; read data lands in v
  task automatic acc(input bit w, input logic [5:0] a, input logic [7:0] x);
  begin
    @(posedge clk);
    hsel   <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a, 2'h0};
    wt;
    hsel   <= 0;
    htrans <= 2'h0;
    hwdata <= {24'h0, x};
    wt;
    v = hrdata[7:0];
  end
  endtask
  initial
  begin
    void'($urandom(32'h86664704));
    repeat (20) @(posedge clk);
    rst <= 0;
    acc(0, 6'h0e, 0);
    `CHK(v, 8'h1f)
    acc(0, 6'h12, 0);
    `CHK(v, 8'h1f)
    acc(0, 6'h14, 0);
    `CHK(v, 8'h00)
    acc(0, 6'h18, 0);
    `CHK(v, 8'h00)
    acc(0, 6'h1a, 0);
    `CHK(v, 8'h00)
    `CHK(oe_n, 1'b1)
    `CHK(rxd, 1'b1)
    $display("test 1 done");
    for (int g = 0; g < 4; g++)
    begin
      b = g == 0 ? 6'h0d : g == 1 ? 6'h10 : g == 2 ? 6'h16 : 6'h19;
      m = g < 2 ? 8'h1f : g == 2 ? 8'hff : 8'h0e;
      d = 8'($urandom);
      acc(1, b, d);
      e = upd(e, d, m, 0);
      acc(0, b + 6'h1, 0);
      `CHK(v, e)
      d = 8'($urandom);
      acc(1, b + 6'h1, d);
      e = upd(e, d, m, 1);
      acc(0, b + 6'h2, 0);
      `CHK(v, e)
      d = 8'($urandom);
      acc(1, b + 6'h2, d);
      e = upd(e, d, m, 2);
      acc(0, b, 0);
      `CHK(v, e)
    end
    $display("test 2 done");
    cmp <= 5'($urandom);
    ls  <= 2'($urandom);
    acc(1, 6'h13, 8'hff);
    acc(0, 6'h13, 0);
    `CHK(v, {3'h0, cmp})
    acc(0, 6'h15, 0);
    `CHK(v, {6'h0, ls})
    acc(1, 6'h3f, 8'hff);
    acc(0, 6'h3f, 0);
    `CHK(v, 8'h00)
    `CHK(hresp, 1'b0)
    $display("test 3 done");
    acc(1, 6'h0d, 8'h1f);
    acc(1, 6'h10, 8'h00);
    acc(1, 6'h30, 8'h1f);
    cmp <= 0;
    acc(0, 6'h14, 0);
    acc(0, 6'h14, 0);
    `CHK(v, 8'h00)
    cmp <= 5'h1f;
    acc(0, 6'h13, 0);
    `CHK(irq, 1'b1)
    acc(0, 6'h14, 0);
    `CHK(v, 8'h1e)
    acc(0, 6'h14, 0);
    `CHK(v, 8'h00)
    `CHK(irq, 1'b0)
    host <= 1;
    cmp  <= 5'h1e;
    acc(1, 6'h30, 8'h00);
    cmp <= 5'h1f;
    acc(0, 6'h14, 0);
    `CHK(v, 8'h01)
    `CHK(irq, 1'b0)
    $display("test 4 done");
    run <= 1;
    acc(1, 6'h19, 8'h0e);
    acc(1, 6'h08, 8'h04);
    @(posedge clk);
    `CHK(mode, 1'b1)
    `CHK(oe_n, 1'b0)
    `CHK(idd, 1'b1)
    repeat (8)
    begin
      d = {6'h0, dp, txd};
      @(posedge clk);
      `CHK(dm, d[0])
      `CHK(rxd, d[1])
    end
    ext <= 1;
    @(posedge clk);
    ext <= 0;
    @(posedge clk);
    `CHK(mode, 1'b0)
    acc(1, 6'h1b, 8'h08);
    @(posedge clk);
    repeat (6)
    begin
      @(posedge clk);
      `CHK(rxd, 1'b1)
    end
    $display("test 5 done");
    results;
  end
endmodule
`default_nettype wire

// ---- verif/ueb_link_model.sv ----
// Link-side model of the UART transmit data and DP line
`default_nettype none
module ueb_link_model (
  input  wire logic i_ref_clk,
  input  wire logic i_run,
  output var logic  o_uart_tx_data,
  output var logic  o_dp_level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Fresh bit every cycle so a stuck path cannot pass; idle high otherwise
  always @(posedge i_ref_clk)
  begin
    o_uart_tx_data <= i_run ? 1'($urandom) : 1'b1;
    o_dp_level     <= i_run ? 1'($urandom) : 1'b1;
  end
endmodule
`default_nettype wire

// ---- verif/ueb_regs_asserts.sv ----
// Checker of bus timing, reserved bits and UART routing
`default_nettype none
module ueb_regs_asserts (
  input wire logic        i_ref_clk,
  input wire logic        i_reset,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic        i_accessory_mode_exit,
  input wire logic        i_uart_tx_data,
  input wire logic        i_dp_level,
  input wire logic        o_dm_uart_data,
  input wire logic        o_dm_uart_oe_n,
  input wire logic        o_uart_rx_data,
  input wire logic        o_accessory_uart_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  logic       take;
  logic       rd_reg;
  logic [5:0] idx_reg;
  assign take = i_hsel && i_htrans[1] && i_hready;
  // Index of the read whose data lands next cycle
  always @(posedge i_ref_clk)
  begin
    rd_reg  <= take && !i_hwrite && !i_reset;
    idx_reg <= i_haddr[7:2];
  end
  AST_RD_WAIT: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  AST_WR_NOWAIT: assert property (take && i_hwrite |=> o_hreadyout)
    else $error("write stalled");
  AST_EVT_RSV: assert property (
    rd_reg && idx_reg inside {[6'h0d:6'h14]} |=> o_hrdata[31:5] == 27'h0)
    else $error("event register high bits set");
  AST_DBG_RSV: assert property (rd_reg && idx_reg == 6'h15 |=> o_hrdata[31:2] == 30'h0)
    else $error("debug high bits set");
  AST_ACC_RSV: assert property (
    rd_reg && idx_reg inside {[6'h19:6'h1b]} |=> o_hrdata[31:4] == 28'h0 && !o_hrdata[0])
    else $error("accessory reserved bits set");
  AST_DM_PATH: assert property (!o_dm_uart_oe_n |-> o_dm_uart_data == $past(i_uart_tx_data))
    else $error("DM data wrong");
  AST_RX_PATH: assert property (!o_uart_rx_data |-> !$past(i_dp_level))
    else $error("receive line low without cause");
  AST_MODE_EXIT: assert property (i_accessory_mode_exit |=> !o_accessory_uart_mode)
    else $error("mode bit kept after exit");
endmodule
bind ueb_regs ueb_regs_asserts chk_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
  .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite),
  .i_hready(i_hready), .o_hreadyout(o_hreadyout), .o_hrdata(o_hrdata),
  .i_accessory_mode_exit(i_accessory_mode_exit), .i_uart_tx_data(i_uart_tx_data),
  .i_dp_level(i_dp_level), .o_dm_uart_data(o_dm_uart_data),
  .o_dm_uart_oe_n(o_dm_uart_oe_n), .o_uart_rx_data(o_uart_rx_data),
  .o_accessory_uart_mode(o_accessory_uart_mode));
`default_nettype wire
